// ===== logic/icl_pkg.sv
package icl_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_KHZ       = 10000;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYC      = TICK_MS * CLK_KHZ;
  localparam int TMR_W         = 13;
  localparam int SHIFT_FAIL_MS = 60000;
  localparam int GPS_HOLD_MS   = 30000;
  localparam int BELT_MS       = 6000;
  localparam int HILL_LOW_MS   = 650;
  localparam int HILL_REP_MS   = 2000;
  localparam int HILL_SPAN_MS  = 30000;

  typedef logic [TMR_W-1:0] icl_tmr_t;

  // least times round up to whole ticks
  localparam icl_tmr_t SHIFT_FAIL_TK =
    TMR_W'((SHIFT_FAIL_MS + TICK_MS - 1) / TICK_MS);
  localparam icl_tmr_t GPS_HOLD_TK =
    TMR_W'((GPS_HOLD_MS + TICK_MS - 1) / TICK_MS);
  localparam icl_tmr_t BELT_TK =
    TMR_W'((BELT_MS + TICK_MS - 1) / TICK_MS);
  localparam icl_tmr_t HILL_LOW_TK =
    TMR_W'((HILL_LOW_MS + TICK_MS - 1) / TICK_MS);
  localparam icl_tmr_t HILL_REP_TK =
    TMR_W'((HILL_REP_MS + TICK_MS - 1) / TICK_MS);
  localparam icl_tmr_t HILL_SPAN_TK =
    TMR_W'((HILL_SPAN_MS + TICK_MS - 1) / TICK_MS);

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] ADDR_CFG  = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  localparam int OPT_W         = 2;
  localparam int BELT_W        = 3;
  localparam int CFG_W         = 10;
  localparam int CFG_SHIFT_LSB = 0;
  localparam int CFG_KEY_LSB   = 2;
  localparam int CFG_TBOX_LSB  = 4;
  localparam int CFG_BELT_LSB  = 6;
  localparam int CFG_KEYIN_BIT = 9;
  localparam logic [CFG_W-1:0] CFG_RST = 10'h06A;

  localparam logic [OPT_W-1:0] OPT_NONE    = 2'h1;
  localparam logic [OPT_W-1:0] OPT_NORMAL  = 2'h2;
  localparam logic [OPT_W-1:0] OPT_INHIBIT = 2'h3;

  localparam logic [BELT_W-1:0] BELT_TIMED = 3'h1;
  localparam logic [BELT_W-1:0] BELT_UNTIL = 3'h2;
  localparam logic [BELT_W-1:0] BELT_UNLESS = 3'h3;
  localparam logic [BELT_W-1:0] BELT_OFF   = 3'h4;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic ign_on;
    logic aux_on;
    logic brake;
    logic in_park;
    logic tbox_neutral;
    logic tbox_range;
    logic key_in;
    logic transit;
    logic link_fail;
    logic theft_armed;
    logic flap_sw;
    logic batt_abn;
    logic belt_fastened;
    logic drv_door_open;
    logic lamps_on;
    logic hill_warn;
  } icl_in_t;

  typedef struct packed {
    logic shift_en;
    logic key_lock_en;
    logic tbox_en;
    logic gps_feed;
    logic flap_en;
  } icl_act_t;

  typedef struct packed {
    logic belt_lamp;
    logic chime5;
    logic chime4;
    logic chime3;
    logic chime2;
    logic chime1;
  } icl_warn_t;

  typedef enum logic [3:0] {
    HW_IDLE   = 4'h1,
    HW_LOW    = 4'h2,
    HW_REPEAT = 4'h4,
    HW_DONE   = 4'h8
  } icl_hill_t;
endpackage

// ===== logic/icl_sync.sv
`timescale 1ns/1ps
module icl_sync #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } icl_sync_st_t;

  icl_sync_st_t q;
  icl_sync_st_t d;

  if (W < 1) begin : g_chk
    $error("icl_sync width must be at least one");
  end

  // first stage feeds only the second
  always_comb begin
    d    = q;
    d.s1 = d_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign q_out = q.s2;
endmodule

// ===== logic/icl_tick.sv
`timescale 1ns/1ps
module icl_tick #(
  parameter int CYC = 100000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  output logic      tick
);
  localparam int CW = (CYC > 1) ? $clog2(CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } icl_tick_st_t;

  icl_tick_st_t q;
  icl_tick_st_t d;

  if (CYC < 2) begin : g_chk
    $error("icl_tick period must be at least two cycles");
  end

  always_comb begin
    d = q;
    if (q.cnt == LAST) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt  = q.cnt + 1'b1;
      d.tick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule

// ===== logic/icl_top.sv
// Overview of operation
// - lever in Park, ignition off: shift interlock solenoid stays off
// - ignition on and brake pressed: request interlock relay on
// - brake released: shift interlock output drops
// - each interlock has option not fitted, normal, inhibit box
// - link failed: shift enable for one minute after ignition on
// - key in: lock key when not in Park or box neutral
// - key released only in Park with box in high or low range
// - transit mode forces the key interlock output off
// - key removal sends box interlock request over the link
// - link failure drops the box interlock enable
// - position switch fed with ignition, removed after 30 s all off
// - flap release only ignition off, unarmed, switch pressed
// - abnormal battery forces flap release off
// - belt option 1: chime one and lamp six seconds
// - belt option 2: six seconds or until belt fastened
// - belt option 3: six seconds only if belt unfastened
// - no warning requests while the link has failed
// - key-in chime two: ignition off, key in, door open
// - ignition on: chime three on each falling edge of hill descent input
// - low beyond 650 ms: chime three every 2 s, at most 30 s
// - box neutral with ignition on requests chime four
// - ignition off, lamps on, door open requests chime five
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
module icl_top
  import icl_pkg::*;
#(
  parameter int TICK_CYCLES = icl_pkg::TICK_CYC
) (
  input  wire logic              REF_CLK,
  input  wire logic              NRST,
  input  wire logic              CE,
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  input  wire icl_pkg::icl_in_t  SW_IN,
  output icl_pkg::icl_act_t      ACT_OUT,
  output icl_pkg::icl_warn_t     WARN_OUT
);
  import icl_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [CFG_W-1:0]  cfg;
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       rdata;
    logic              ready;
    icl_in_t           in_prev;
    icl_tmr_t          shift_tmr;
    icl_tmr_t          gps_tmr;
    icl_tmr_t          belt_tmr;
    icl_tmr_t          hill_tmr;
    icl_tmr_t          span_tmr;
    icl_hill_t         hill_st;
    icl_act_t          act;
    icl_warn_t         warn;
  } icl_top_st_t;

  icl_top_st_t q;
  icl_top_st_t d;
  icl_in_t     s;
  logic        tick;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("icl_top tick period must be at least two cycles");
  end

  icl_sync #(
    .W ($bits(icl_in_t))
  ) u_sync (
    .clk   (REF_CLK),
    .rst_n (NRST),
    .ce    (CE),
    .d_in  (SW_IN),
    .q_out (s)
  );

  icl_tick #(
    .CYC (TICK_CYCLES)
  ) u_tick (
    .clk   (REF_CLK),
    .rst_n (NRST),
    .ce    (CE),
    .tick  (tick)
  );

  function automatic logic fitted(input logic [OPT_W-1:0] o);
    fitted = (o == OPT_NORMAL) || (o == OPT_INHIBIT);
  endfunction

  logic [OPT_W-1:0]  shift_opt;
  logic [OPT_W-1:0]  key_opt;
  logic [OPT_W-1:0]  tbox_opt;
  logic [BELT_W-1:0] belt_opt;
  logic              keyin_off;
  logic              ign_rise;
  logic              key_rise;
  logic              key_fall;
  logic              hill_fall;

  assign shift_opt = q.cfg[CFG_SHIFT_LSB +: OPT_W];
  assign key_opt   = q.cfg[CFG_KEY_LSB +: OPT_W];
  assign tbox_opt  = q.cfg[CFG_TBOX_LSB +: OPT_W];
  assign belt_opt  = q.cfg[CFG_BELT_LSB +: BELT_W];
  assign keyin_off = q.cfg[CFG_KEYIN_BIT];
  assign ign_rise  = s.ign_on && !q.in_prev.ign_on;
  assign key_rise  = s.key_in && !q.in_prev.key_in;
  assign key_fall  = !s.key_in && q.in_prev.key_in;
  assign hill_fall = q.in_prev.hill_warn && !s.hill_warn;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic ok;
    logic belt_on;
    logic hill_pulse;
    ok         = !s.link_fail;
    belt_on    = 1'b0;
    hill_pulse = 1'b0;
    d          = q;
    d.in_prev  = s;
    d.ready    = 1'b1;

    // zero-wait slave: read data is captured in the address phase
    d.wr_pend = 1'b0;
    if (HSEL && HREADY && HTRANS[1]) begin
      d.wr_pend = HWRITE && (HSIZE == SIZE_WORD);
      d.wr_addr = HADDR[ADDR_W-1:0];
      if (HWRITE) begin
        d.rdata = '0;
      end else if (HADDR[ADDR_W-1:0] == ADDR_CFG) begin
        d.rdata = 32'(q.cfg);
      end else if (HADDR[ADDR_W-1:0] == ADDR_STAT) begin
        d.rdata = 32'({s, q.act, q.warn});
      end else begin
        d.rdata = '0;
      end
    end
    if (q.wr_pend && q.wr_addr == ADDR_CFG) begin
      d.cfg = HWDATA[CFG_W-1:0];
    end

    if (ign_rise) begin
      d.shift_tmr = SHIFT_FAIL_TK;
    end else if (!s.ign_on) begin
      d.shift_tmr = '0;
    end else if (tick && q.shift_tmr != '0) begin
      d.shift_tmr = q.shift_tmr - 1'b1;
    end
    // ignition and brake gate the relay request; with a failed link, ignition and the one-minute timer
    if (!fitted(shift_opt)) begin
      d.act.shift_en = 1'b0;
    end else if (s.link_fail) begin
      d.act.shift_en = s.ign_on && (d.shift_tmr != '0);
    end else begin
      d.act.shift_en = s.ign_on && s.brake;
    end

    d.act.key_lock_en = fitted(key_opt) && s.key_in && !s.transit &&
                        (!s.in_park || s.tbox_neutral || !s.tbox_range);

    // box request sent on key removal, dropped on failure
    if (!fitted(tbox_opt) || s.link_fail || key_rise) begin
      d.act.tbox_en = 1'b0;
    end else if (key_fall) begin
      d.act.tbox_en = 1'b1;
    end

    // feed holds until ignition and auxiliary off past 30 s
    if (s.ign_on || s.aux_on) begin
      d.gps_tmr = '0;
    end else if (tick && q.gps_tmr <= GPS_HOLD_TK) begin
      d.gps_tmr = q.gps_tmr + 1'b1;
    end
    if (s.ign_on) begin
      d.act.gps_feed = 1'b1;
    end else if (d.gps_tmr > GPS_HOLD_TK) begin
      d.act.gps_feed = 1'b0;
    end

    d.act.flap_en = !s.ign_on && !s.theft_armed && s.flap_sw &&
                    !s.batt_abn;

    if (!s.ign_on) begin
      d.belt_tmr = '0;
    end else if (ign_rise && (belt_opt == BELT_TIMED ||
                              belt_opt == BELT_UNTIL ||
                              (belt_opt == BELT_UNLESS &&
                               !s.belt_fastened))) begin
      d.belt_tmr = BELT_TK;
    end else if (belt_opt == BELT_UNTIL && s.belt_fastened) begin
      d.belt_tmr = '0;
    end else if (tick && q.belt_tmr != '0) begin
      d.belt_tmr = q.belt_tmr - 1'b1;
    end
    belt_on = d.belt_tmr != '0;

    case (q.hill_st)
      HW_IDLE: begin
        d.hill_tmr = '0;
        if (hill_fall) begin
          hill_pulse = 1'b1;
          d.hill_st  = HW_LOW;
        end
      end
      HW_LOW: begin
        if (s.hill_warn) begin
          d.hill_st = HW_IDLE;
        end else if (tick) begin
          if (q.hill_tmr == HILL_LOW_TK - 1'b1) begin
            hill_pulse = 1'b1;
            d.hill_tmr = '0;
            d.span_tmr = '0;
            d.hill_st  = HW_REPEAT;
          end else begin
            d.hill_tmr = q.hill_tmr + 1'b1;
          end
        end
      end
      HW_REPEAT: begin
        if (s.hill_warn) begin
          d.hill_st = HW_IDLE;
        end else if (tick) begin
          d.span_tmr = q.span_tmr + 1'b1;
          if (q.span_tmr == HILL_SPAN_TK - 1'b1) begin
            d.hill_st = HW_DONE;
          end else if (q.hill_tmr == HILL_REP_TK - 1'b1) begin
            hill_pulse = 1'b1;
            d.hill_tmr = '0;
          end else begin
            d.hill_tmr = q.hill_tmr + 1'b1;
          end
        end
      end
      HW_DONE: begin
        if (s.hill_warn) begin
          d.hill_st = HW_IDLE;
        end
      end
      default: begin
        d.hill_st = HW_IDLE;
      end
    endcase
    if (!s.ign_on) begin
      d.hill_st  = HW_IDLE;
      hill_pulse = 1'b0;
    end

    // a failed link silences every request
    d.warn.chime1    = ok && belt_on;
    d.warn.belt_lamp = ok && belt_on;
    d.warn.chime2 = ok && !keyin_off && !s.ign_on && s.key_in &&
                    s.drv_door_open;
    d.warn.chime3 = ok && hill_pulse;
    d.warn.chime4 = ok && s.tbox_neutral && s.ign_on;
    d.warn.chime5 = ok && !s.ign_on && s.lamps_on && s.drv_door_open;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      q         <= '0;
      q.cfg     <= CFG_RST;
      q.ready   <= 1'b1;
      q.hill_st <= HW_IDLE;
    end else if (CE) begin
      q <= d;
    end
  end

  assign HRDATA    = q.rdata;
  assign HREADYOUT = q.ready;
  assign HRESP     = 1'b0;
  assign ACT_OUT   = q.act;
  assign WARN_OUT  = q.warn;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  sequence ign_rise_s;
    CE && s.ign_on && !q.in_prev.ign_on && !s.link_fail;
  endsequence

  sequence hill_fall_s;
    CE && s.ign_on && !s.link_fail && q.in_prev.hill_warn &&
    !s.hill_warn;
  endsequence

  flap_batt_a: assert property (CE && s.batt_abn
      |=> !ACT_OUT.flap_en)
    else $error("flap release on with abnormal battery");
  flap_cond_a: assert property (CE && !s.ign_on && !s.theft_armed &&
      s.flap_sw && !s.batt_abn |=> ACT_OUT.flap_en)
    else $error("flap release missing");
  key_transit_a: assert property (CE && s.transit
      |=> !ACT_OUT.key_lock_en)
    else $error("key lock on in transit mode");
  key_free_a: assert property (CE && s.in_park && s.tbox_range &&
      !s.tbox_neutral |=> !ACT_OUT.key_lock_en)
    else $error("key held in Park with range engaged");
  shift_brake_a: assert property (CE && !s.link_fail && !s.brake
      |=> !ACT_OUT.shift_en)
    else $error("shift interlock on without brake");
  link_quiet_a: assert property (CE && s.link_fail
      |=> WARN_OUT == '0)
    else $error("warning sent with failed link");
  tbox_fail_a: assert property (CE && s.link_fail
      |=> !ACT_OUT.tbox_en)
    else $error("box enable kept with failed link");
  chime_four_a: assert property (CE && !s.link_fail && s.ign_on &&
      s.tbox_neutral |=> WARN_OUT.chime4)
    else $error("box neutral chime missing");
  hill_edge_a: assert property (hill_fall_s |=> WARN_OUT.chime3)
    else $error("hill chime missing on falling edge");
  feed_on_a: assert property (CE && s.ign_on |=> ACT_OUT.gps_feed)
    else $error("position switch feed off with ignition");
  belt_start_a: assert property (ign_rise_s and
      (belt_opt == BELT_TIMED) |=> WARN_OUT.belt_lamp && WARN_OUT.chime1)
    else $error("belt warning not started");
endmodule

// ===== tb/icl_far_model.sv
`timescale 1ns/1ps
module icl_far_model (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire icl_pkg::icl_act_t  act,
  input  wire icl_pkg::icl_warn_t warn,
  output logic                    shift_relay,
  output logic                    tbox_relay,
  output logic [15:0]             chime3_cnt
);
  import icl_pkg::*;
  // ****************************************************************
  // driver module relays and cluster chime counter
  // ****************************************************************
  // relays pull in one cycle after their enable, like a real coil driver
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_relay <= 1'b0;
      tbox_relay  <= 1'b0;
      chime3_cnt  <= 16'h0000;
    end else begin
      shift_relay <= act.shift_en;
      tbox_relay  <= act.tbox_en;
      chime3_cnt  <= chime3_cnt + 16'(warn.chime3);
    end
  end
endmodule

// ===== tb/test_interlock_and_chime_logic.sv
`timescale 1ns/1ps
module test_interlock_and_chime_logic;
  import icl_pkg::*;
  // short tick keeps the minute-long timers inside the run
  localparam int TK = 4;
  logic              clk, nrst, ce, hsel, hwrite, hreadyout, hresp;
  logic       [31:0] haddr, hwdata, hrdata;
  logic       [1:0]  htrans;
  logic       [2:0]  hsize;
  logic       [15:0] c3;
  logic              shift_relay, tbox_relay;
  icl_in_t           sw, nx;
  icl_act_t          act;
  icl_warn_t         warn;
  int                bad_count, n_compared;

  icl_top #(.TICK_CYCLES(TK)) DUT (
    .REF_CLK   (clk),
    .NRST      (nrst),
    .CE        (ce),
    .HSEL      (hsel),
    .HADDR     (haddr),
    .HTRANS    (htrans),
    .HWRITE    (hwrite),
    .HSIZE     (hsize),
    .HWDATA    (hwdata),
    .HREADY    (hreadyout),
    .HRDATA    (hrdata),
    .HREADYOUT (hreadyout),
    .HRESP     (hresp),
    .SW_IN     (sw),
    .ACT_OUT   (act),
    .WARN_OUT  (warn)
  );

  icl_far_model FAR (
    .clk         (clk),
    .rst_n       (nrst),
    .act         (act),
    .warn        (warn),
    .shift_relay (shift_relay),
    .tbox_relay  (tbox_relay),
    .chime3_cnt  (c3)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // outputs trail the switches by three edges, so four is safe
  task automatic go();
    @(posedge clk);
    sw <= nx;
    settle(4);
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic cfgw(input logic [2:0] belt, input logic [1:0] box,
                      input logic koff);
    logic [31:0] r;
    ahb(1'b1, ADDR_CFG, {22'h0, koff, belt, box, OPT_NORMAL, OPT_NORMAL}, r);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [31:0] r;
    ahb(1'b0, ADDR_CFG, 32'h0, r);
    chk("cfg reset", {22'h0, CFG_RST}, r);
    chk("outputs idle", 11'h000, {act, warn});
    chk("hresp", 1'b0, hresp);
    chk("hreadyout", 1'b1, hreadyout);
    ahb(1'b1, ADDR_CFG, 32'hFFFFFFFF, r);
    ahb(1'b0, ADDR_CFG, 32'h0, r);
    chk("cfg rw", 32'h000003FF, r);
    // a byte-sized write must leave the options alone
    hsize <= 3'h0;
    ahb(1'b1, ADDR_CFG, 32'h00000000, r);
    hsize <= SIZE_WORD;
    ahb(1'b0, ADDR_CFG, 32'h0, r);
    chk("cfg byte write", 32'h000003FF, r);
    ahb(1'b1, ADDR_STAT, 32'hFFFFFFFF, r);
    ahb(1'b0, ADDR_STAT, 32'h0, r);
    chk("stat", {5'h00, nx, 11'h000}, r);
    ahb(1'b0, 8'h10, 32'h0, r);
    chk("unmapped", 32'h0, r);
    cfgw(BELT_TIMED, OPT_NORMAL, 1'b0);
  endtask

  task automatic t_shift();
    nx.ign_on = 1'b1;
    nx.brake = 1'b1;
    go();
    chk("shift on", 1'b1, act.shift_en);
    chk("shift relay", 1'b1, shift_relay);
    nx.brake = 1'b0;
    go();
    chk("shift brake off", 1'b0, act.shift_en);
    nx.ign_on = 1'b0;
    go();
    nx.link_fail = 1'b1;
    nx.ign_on = 1'b1;
    go();
    chk("warn muted", 6'h00, warn);
    chk("shift link fail", 1'b1, act.shift_en);
    nx.ign_on = 1'b0;
    go();
    chk("shift ign off", 1'b0, act.shift_en);
    nx.ign_on = 1'b1;
    go();
    settle(TK * 6000 - 200);
    chk("shift before 60 s", 1'b1, act.shift_en);
    settle(400);
    chk("shift after 60 s", 1'b0, act.shift_en);
    nx.ign_on = 1'b0;
    nx.link_fail = 1'b0;
    go();
  endtask

  task automatic t_ce();
    @(posedge clk);
    ce <= 1'b0;
    nx.ign_on = 1'b1;
    nx.brake = 1'b1;
    go();
    settle(8);
    chk("frozen by enable", 1'b0, act.shift_en);
    @(posedge clk);
    ce <= 1'b1;
    settle(4);
    chk("enable resumes", 1'b1, act.shift_en);
    nx.ign_on = 1'b0;
    nx.brake = 1'b0;
    go();
  endtask

  task automatic t_key();
    // park, neutral, range, transit, expected lock
    logic [4:0] tb [6] = '{5'b00101, 5'b10100, 5'b11101, 5'b10001,
                           5'b00110, 5'b11010};
    nx.key_in = 1'b1;
    foreach (tb[i]) begin
      {nx.in_park, nx.tbox_neutral, nx.tbox_range, nx.transit} = tb[i][4:1];
      go();
      chk("key lock", tb[i][0], act.key_lock_en);
    end
    {nx.in_park, nx.tbox_neutral, nx.tbox_range, nx.transit} = 4'hA;
    go();
  endtask

  task automatic t_tbox();
    logic [1:0] opt [3] = '{OPT_NORMAL, OPT_NONE, OPT_INHIBIT};
    foreach (opt[i]) begin
      cfgw(BELT_TIMED, opt[i], 1'b0);
      nx.key_in = 1'b0;
      go();
      chk("box enable", opt[i] != OPT_NONE, act.tbox_en);
      chk("box relay", opt[i] != OPT_NONE, tbox_relay);
      nx.key_in = 1'b1;
      go();
    end
    nx.key_in = 1'b0;
    go();
    nx.link_fail = 1'b1;
    go();
    chk("box on link fail", 1'b0, act.tbox_en);
    nx.link_fail = 1'b0;
    go();
    cfgw(BELT_TIMED, OPT_NORMAL, 1'b0);
  endtask

  task automatic t_gps();
    nx.ign_on = 1'b1;
    go();
    chk("feed with ign", 1'b1, act.gps_feed);
    // auxiliary on restarts the hold, so ignition off alone is not enough
    nx.ign_on = 1'b0;
    nx.aux_on = 1'b1;
    go();
    settle(800);
    nx.aux_on = 1'b0;
    go();
    settle(TK * 3000 - 200);
    chk("feed held", 1'b1, act.gps_feed);
    settle(400);
    chk("feed removed", 1'b0, act.gps_feed);
  endtask

  task automatic t_flap();
    // ignition, armed, switch, battery abnormal, expected
    logic [4:0] tb [5] = '{5'b00101, 5'b10100, 5'b01100, 5'b00000,
                           5'b00110};
    foreach (tb[i]) begin
      {nx.ign_on, nx.theft_armed, nx.flap_sw, nx.batt_abn} = tb[i][4:1];
      go();
      chk("flap", tb[i][0], act.flap_en);
    end
    {nx.ign_on, nx.theft_armed, nx.flap_sw, nx.batt_abn} = 4'h0;
    go();
  endtask

  task automatic t_belt();
    // option, fastened at start, fastened later, three expectations
    logic [7:0] tb [5] = '{8'h3F, 8'h4C, 8'h78, 8'h67, 8'h80};
    foreach (tb[i]) begin
      nx.ign_on = 1'b0;
      nx.belt_fastened = tb[i][4];
      go();
      cfgw(tb[i][7:5], OPT_NORMAL, 1'b0);
      nx.ign_on = 1'b1;
      go();
      settle(96);
      chk("belt early", {2{tb[i][2]}}, {warn.belt_lamp, warn.chime1});
      nx.belt_fastened = tb[i][3];
      go();
      settle(96);
      chk("belt mid", {2{tb[i][1]}}, {warn.belt_lamp, warn.chime1});
      settle(2000);
      chk("belt late", {2{tb[i][0]}}, {warn.belt_lamp, warn.chime1});
      settle(300);
      chk("belt over", 2'h0, {warn.belt_lamp, warn.chime1});
    end
    nx.ign_on = 1'b0;
    nx.belt_fastened = 1'b0;
    go();
    cfgw(BELT_TIMED, OPT_NORMAL, 1'b0);
  endtask

  task automatic t_chimes();
    // ignition, key, door, lamps, neutral, key-in off, chimes 5 4 2
    logic [8:0] tb [5] = '{9'h0C1, 9'h0C8, 9'h1F2, 9'h074, 9'h0A0};
    foreach (tb[i]) begin
      cfgw(BELT_TIMED, OPT_NORMAL, tb[i][3]);
      {nx.ign_on, nx.key_in, nx.drv_door_open, nx.lamps_on,
       nx.tbox_neutral} = tb[i][8:4];
      go();
      chk("chimes", tb[i][2:0],
          {warn.chime5, warn.chime4, warn.chime2});
    end
    {nx.ign_on, nx.key_in, nx.drv_door_open, nx.lamps_on,
     nx.tbox_neutral} = 5'h00;
    go();
    cfgw(BELT_TIMED, OPT_NORMAL, 1'b0);
  endtask

  task automatic t_hill();
    logic [15:0] b;
    nx.ign_on = 1'b1;
    nx.hill_warn = 1'b1;
    go();
    b = c3;
    repeat (3) begin
      nx.hill_warn = 1'b0;
      go();
      settle(16);
      nx.hill_warn = 1'b1;
      go();
      settle(16);
    end
    chk("chime3 per fall", 16'h0003, c3 - b);
    b = c3;
    nx.hill_warn = 1'b0;
    go();
    settle(1100);
    chk("chime3 repeats", 16'h0003, c3 - b);
    settle(13000);
    b = c3;
    settle(1000);
    chk("chime3 span end", 16'h0000, c3 - b);
  endtask

  // ****************************************************************
  // clock, reset, sequence and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = SIZE_WORD;
    hwdata = 32'h0;
    nx = '0;
    nx.in_park = 1'b1;
    nx.tbox_range = 1'b1;
    sw = nx;
    bad_count = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_shift();
    t_ce();
    t_key();
    t_tbox();
    t_gps();
    t_flap();
    t_belt();
    t_chimes();
    t_hill();
    report_and_stop();
  end

  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule
